// ---- dcs_regs.sv ----
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dcs_map.svh"

// Notes on behaviour
// - Ethernet config bit 18 high holds RMII logic in reset; low releases it.
// - Emulation buffer bit 0 high powers down emulation pin buffers 18..2.
// - Device status captures reset-time configuration and holds until next reset.
// - Peripheral enable changes never alter the device status register.
// - Each status field latches its configuration pin on the first clock edge after reset release.
// - Status bits 31:23 read zero, bits 16 and 8 read one, register read-only.
// - Status bit 22 shows whether async memory interface pins are enabled.
// - Status bit 21 shows whether DRAM controller pins are enabled.
// - Status bit 20 selects PCI pins when one, host and cell pins when zero.
// - Status bits 19:17 show three general configuration inputs latched at reset.
// - Status bit 15 selects clock output when one, general I/O one when zero.
// - MAC select field codes 00 MII, 01 RMII, 10 GMII, 11 RGMII.
// - Endian status bit reads one for little endian, zero for big endian.
// - Boot mode field reports latched boot setting; its peripheral enables automatically.

module dcs_regs #(
    parameter int ADDR_W = 32
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic async_memif_pin,
    input wire logic dram_ctrl_pin,
    input wire logic pci_select_pin,
    input wire logic [2:0] boot_config_pins,
    input wire logic clock_output_pin,
    input wire logic serial_port1_pin,
    input wire logic pci_fast_pin,
    input wire logic serial_link_pin,
    input wire logic pci_eeprom_pin,
    input wire logic [1:0] mac_select_pins,
    input wire logic cell_if_pin,
    input wire logic byte_order_pin,
    input wire logic host_wide_pin,
    input wire logic memif_clock_pin,
    input wire logic [3:0] boot_mode_pins,
    output logic rmii_logic_reset,
    output logic emu_buffer_off,
    output logic [16:0] emulation_pins_off,
    output logic async_memif_pins_on,
    output logic dram_ctrl_pins_on,
    output logic pci_pins_selected,
    output logic [2:0] boot_config_inputs,
    output logic clock_output_selected,
    output logic [1:0] mac_interface_select,
    output logic byte_order_flag,
    output logic [3:0] boot_configuration,
    output logic [15:0] boot_periph_enable,
    output logic status_valid
);

    if (ADDR_W < `DCS_MIN_ADDR_W || ADDR_W > 32) begin : g_bad_addr
        $error("dcs_regs address width must lie between 26 and 32 bits.");
    end

    dcs_pkg::dcs_top_state_t state_reg;
    dcs_pkg::dcs_top_state_t state_next;

    logic [31:0] strap_pins;
    logic [31:0] status_value;
    logic status_captured;
    logic [31:0] eth_value;
    logic [31:0] emu_value;
    logic eth_wr;
    logic emu_wr;
    dcs_pkg::dcs_sel_t sel;

    function automatic dcs_pkg::dcs_sel_t decode(input logic [ADDR_W-1:0] a);
        dcs_pkg::dcs_sel_t s;
        s = dcs_pkg::DCS_SEL_NONE;
        if (a == ADDR_W'(`DCS_STATUS_ADDR)) begin
            s = dcs_pkg::DCS_SEL_STATUS;
        end else if (a == ADDR_W'(`DCS_ETH_CFG_ADDR)) begin
            s = dcs_pkg::DCS_SEL_ETH;
        end else if (a == ADDR_W'(`DCS_EMU_BUF_ADDR)) begin
            s = dcs_pkg::DCS_SEL_EMU;
        end
        return s;
    endfunction

    // Boot mode zero still gets bit zero; the consumer decides which bits matter.
    function automatic logic [15:0] boot_onehot(input logic [3:0] mode);
        logic [15:0] v;
        v = 16'h0000;
        v[mode] = 1'b1;
        return v;
    endfunction

    // Gather the configuration pins into register order; fixed bits are filled by the latch.
    always_comb begin
        strap_pins = 32'h0000_0000;
        strap_pins[`DCS_ST_ASYNC_BIT] = async_memif_pin;
        strap_pins[`DCS_ST_DRAM_BIT] = dram_ctrl_pin;
        strap_pins[`DCS_ST_PCI_BIT] = pci_select_pin;
        strap_pins[`DCS_ST_CFG_MSB:`DCS_ST_CFG_LSB] = boot_config_pins;
        strap_pins[`DCS_ST_CLKOUT_BIT] = clock_output_pin;
        strap_pins[`DCS_ST_SER1_BIT] = serial_port1_pin;
        strap_pins[`DCS_ST_PCI66_BIT] = pci_fast_pin;
        strap_pins[`DCS_ST_LINK_BIT] = serial_link_pin;
        strap_pins[`DCS_ST_EEAI_BIT] = pci_eeprom_pin;
        strap_pins[`DCS_ST_MAC_MSB:`DCS_ST_MAC_LSB] = mac_select_pins;
        strap_pins[`DCS_ST_CELL_BIT] = cell_if_pin;
        strap_pins[`DCS_ST_ENDIAN_BIT] = byte_order_pin;
        strap_pins[`DCS_ST_HPIW_BIT] = host_wide_pin;
        strap_pins[`DCS_ST_MEMCLK_BIT] = memif_clock_pin;
        strap_pins[`DCS_ST_BOOT_MSB:`DCS_ST_BOOT_LSB] = boot_mode_pins;
    end

    // The status latch has no write port at all, so no bus or peripheral
    // enable activity can disturb it before the next device reset.
    dcs_strap_latch #(
        .RESET_VAL(`DCS_STAT_RESET_VAL),
        .FIXED_MASK(`DCS_STAT_FIXED_MASK)
    ) u_status (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pins(strap_pins),
        .value(status_value),
        .captured(status_captured)
    );

    dcs_ctrl_reg #(
        .RESET_VAL(`DCS_ETH_RESET_VAL),
        .WR_MASK(`DCS_ETH_WR_MASK)
    ) u_eth_cfg (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_en(eth_wr),
        .byteenable(avs_byteenable),
        .wdata(avs_writedata),
        .value(eth_value)
    );

    dcs_ctrl_reg #(
        .RESET_VAL(`DCS_EMU_RESET_VAL),
        .WR_MASK(`DCS_EMU_WR_MASK)
    ) u_emu_buf (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_en(emu_wr),
        .byteenable(avs_byteenable),
        .wdata(avs_writedata),
        .value(emu_value)
    );

    assign sel = decode(avs_address);

    // Writes land only once per transfer, in the idle cycle that accepts it.
    // Reserved bits of the control registers are not stored, so a careless
    // write of nonzero reserved bits cannot upset anything.
    assign eth_wr = (state_reg.bus == dcs_pkg::DCS_BUS_IDLE) && avs_write && !avs_read
        && (sel == dcs_pkg::DCS_SEL_ETH);
    assign emu_wr = (state_reg.bus == dcs_pkg::DCS_BUS_IDLE) && avs_write && !avs_read
        && (sel == dcs_pkg::DCS_SEL_EMU);

    // Every transfer takes exactly one wait cycle: the request is taken in
    // idle, then waitrequest drops for one cycle with data and response.
    always_comb begin
        state_next = state_reg;
        state_next.boot_en = status_captured
            ? boot_onehot(status_value[`DCS_ST_BOOT_MSB:`DCS_ST_BOOT_LSB])
            : 16'h0000;
        unique case (state_reg.bus)
            dcs_pkg::DCS_BUS_IDLE: begin
                state_next.waitreq = 1'b1;
                if (avs_read ^ avs_write) begin
                    state_next.bus = dcs_pkg::DCS_BUS_ACK;
                    state_next.waitreq = 1'b0;
                    state_next.rdata = 32'h0000_0000;
                    state_next.resp = `DCS_RESP_OKAY;
                    unique case (sel)
                        dcs_pkg::DCS_SEL_STATUS: begin
                            // Writes here are accepted and dropped.
                            if (avs_read) begin
                                state_next.rdata = status_value;
                            end
                        end
                        dcs_pkg::DCS_SEL_ETH: begin
                            if (avs_read) begin
                                state_next.rdata = eth_value;
                            end
                        end
                        dcs_pkg::DCS_SEL_EMU: begin
                            if (avs_read) begin
                                state_next.rdata = emu_value;
                            end
                        end
                        dcs_pkg::DCS_SEL_NONE: begin
                            state_next.resp = `DCS_RESP_SLVERR;
                        end
                    endcase
                end
            end
            dcs_pkg::DCS_BUS_ACK: begin
                // The master releases its request at this edge; do not take it twice.
                state_next.bus = dcs_pkg::DCS_BUS_IDLE;
                state_next.waitreq = 1'b1;
                state_next.rdata = 32'h0000_0000;
                state_next.resp = `DCS_RESP_OKAY;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '{
                bus: dcs_pkg::DCS_BUS_IDLE,
                waitreq: 1'b1,
                rdata: 32'h0000_0000,
                resp: `DCS_RESP_OKAY,
                boot_en: 16'h0000
            };
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata = state_reg.rdata;
    assign avs_waitrequest = state_reg.waitreq;
    assign avs_response = state_reg.resp;

    // Control outputs come straight from the stored control bits.
    assign rmii_logic_reset = eth_value[`DCS_ETH_RMII_RST_BIT];
    assign emu_buffer_off = emu_value[`DCS_EMU_OFF_BIT];
    assign emulation_pins_off = {`DCS_EMU_PIN_COUNT{emu_value[`DCS_EMU_OFF_BIT]}};

    // Latched configuration fields, for the pin muxes and boot logic.
    assign async_memif_pins_on = status_value[`DCS_ST_ASYNC_BIT];
    assign dram_ctrl_pins_on = status_value[`DCS_ST_DRAM_BIT];
    assign pci_pins_selected = status_value[`DCS_ST_PCI_BIT];
    assign boot_config_inputs = status_value[`DCS_ST_CFG_MSB:`DCS_ST_CFG_LSB];
    assign clock_output_selected = status_value[`DCS_ST_CLKOUT_BIT];
    assign mac_interface_select = status_value[`DCS_ST_MAC_MSB:`DCS_ST_MAC_LSB];
    assign byte_order_flag = status_value[`DCS_ST_ENDIAN_BIT];
    assign boot_configuration = status_value[`DCS_ST_BOOT_MSB:`DCS_ST_BOOT_LSB];
    assign boot_periph_enable = state_reg.boot_en;
    assign status_valid = status_captured;

endmodule

// ---- dcs_map.svh ----
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH

// Byte addresses of the three registers.
`define DCS_STATUS_ADDR 32'h02A8_0000
`define DCS_ETH_CFG_ADDR 32'h02AC_0020
`define DCS_EMU_BUF_ADDR 32'h02AC_0054
`define DCS_MIN_ADDR_W 26

// Ethernet configuration register.
`define DCS_ETH_RESET_VAL 32'h0000_0000
`define DCS_ETH_WR_MASK 32'h0004_0000
`define DCS_ETH_RMII_RST_BIT 18

// Emulation buffer powerdown register.
`define DCS_EMU_RESET_VAL 32'h0000_0000
`define DCS_EMU_WR_MASK 32'h0000_0001
`define DCS_EMU_OFF_BIT 0
`define DCS_EMU_PIN_COUNT 17

// Device status register: pull-resistor defaults and bits that never follow a pin.
`define DCS_STAT_RESET_VAL 32'h0001_0140
`define DCS_STAT_FIXED_MASK 32'hFF81_0100
`define DCS_ST_ASYNC_BIT 22
`define DCS_ST_DRAM_BIT 21
`define DCS_ST_PCI_BIT 20
`define DCS_ST_CFG_MSB 19
`define DCS_ST_CFG_LSB 17
`define DCS_ST_CLKOUT_BIT 15
`define DCS_ST_SER1_BIT 14
`define DCS_ST_PCI66_BIT 13
`define DCS_ST_LINK_BIT 12
`define DCS_ST_EEAI_BIT 11
`define DCS_ST_MAC_MSB 10
`define DCS_ST_MAC_LSB 9
`define DCS_ST_CELL_BIT 7
`define DCS_ST_ENDIAN_BIT 6
`define DCS_ST_HPIW_BIT 5
`define DCS_ST_MEMCLK_BIT 4
`define DCS_ST_BOOT_MSB 3
`define DCS_ST_BOOT_LSB 0

// Avalon-MM response codes.
`define DCS_RESP_OKAY 2'h0
`define DCS_RESP_SLVERR 2'h2

`endif

// ---- dcs_pkg.sv ----
package dcs_pkg;

    typedef enum logic [0:0] {
        DCS_BUS_IDLE = 1'b0,
        DCS_BUS_ACK = 1'b1
    } dcs_bus_state_t;

    typedef enum logic [1:0] {
        DCS_SEL_NONE = 2'b00,
        DCS_SEL_STATUS = 2'b01,
        DCS_SEL_ETH = 2'b10,
        DCS_SEL_EMU = 2'b11
    } dcs_sel_t;

    typedef enum logic [1:0] {
        DCS_MAC_MII = 2'b00,
        DCS_MAC_RMII = 2'b01,
        DCS_MAC_GMII = 2'b10,
        DCS_MAC_RGMII = 2'b11
    } dcs_mac_if_t;

    typedef struct packed {
        dcs_bus_state_t bus;
        logic waitreq;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic [15:0] boot_en;
    } dcs_top_state_t;

    typedef struct packed {
        logic [31:0] value;
    } dcs_ctrl_state_t;

    typedef struct packed {
        logic [31:0] value;
        logic captured;
    } dcs_strap_state_t;

endpackage

// ---- dcs_ctrl_reg.sv ----
`timescale 1ns/1ps
`include "dcs_map.svh"

module dcs_ctrl_reg #(
    parameter logic [31:0] RESET_VAL = 32'h0000_0000,
    parameter logic [31:0] WR_MASK = 32'h0000_0001
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] wdata,
    output logic [31:0] value
);

    dcs_pkg::dcs_ctrl_state_t state_reg;
    dcs_pkg::dcs_ctrl_state_t state_next;

    if (WR_MASK == 32'h0000_0000) begin : g_bad_mask
        $error("dcs_ctrl_reg needs at least one writable bit.");
    end

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    // Only control bits are stored; reserved bits always read their reset value.
    always_comb begin
        logic [31:0] m;
        m = 32'h0000_0000;
        state_next = state_reg;
        if (wr_en) begin
            m = lane_mask(byteenable) & WR_MASK;
            state_next.value = (state_reg.value & ~m) | (wdata & m);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '{value: RESET_VAL};
        end else begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.value;

endmodule

// ---- dcs_strap_latch.sv ----
`timescale 1ns/1ps
`include "dcs_map.svh"

module dcs_strap_latch #(
    parameter logic [31:0] RESET_VAL = 32'h0000_0000,
    parameter logic [31:0] FIXED_MASK = 32'h0000_0000
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [31:0] pins,
    output logic [31:0] value,
    output logic captured
);

    dcs_pkg::dcs_strap_state_t state_reg;
    dcs_pkg::dcs_strap_state_t state_next;

    // The pins are caught on the first edge after reset release, never under the
    // asynchronous reset, so the reset branch holds only constants.
    always_comb begin
        state_next = state_reg;
        if (!state_reg.captured) begin
            state_next.value = (pins & ~FIXED_MASK) | (RESET_VAL & FIXED_MASK);
            state_next.captured = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '{value: RESET_VAL, captured: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.value;
    assign captured = state_reg.captured;

endmodule

// ---- dcs_regs_asserts.sv ----
`timescale 1ns/1ps
`include "dcs_map.svh"

module dcs_regs_asserts #(
    parameter int ADDR_W = 32
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire logic async_memif_pin,
    input wire logic [1:0] mac_select_pins,
    input wire logic [3:0] boot_mode_pins,
    input wire logic rmii_logic_reset,
    input wire logic emu_buffer_off,
    input wire logic [16:0] emulation_pins_off,
    input wire logic async_memif_pins_on,
    input wire logic [1:0] mac_interface_select,
    input wire logic [3:0] boot_configuration,
    input wire logic [15:0] boot_periph_enable,
    input wire logic status_valid
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // A request seen while waitrequest is high is always a newly taken one.
    logic eth_take;
    logic emu_take;
    logic done;
    assign eth_take = avs_write && avs_waitrequest && avs_address == ADDR_W'(`DCS_ETH_CFG_ADDR);
    assign emu_take = avs_write && avs_waitrequest && avs_address == ADDR_W'(`DCS_EMU_BUF_ADDR);
    assign done = !avs_waitrequest;

    property p_emu_pins;
        emulation_pins_off == {17{emu_buffer_off}};
    endproperty
    a_emu_pins: assert property (p_emu_pins) else $error("emulation pins disagree with control bit");
    property p_emu_write;
        emu_take && avs_byteenable[0] |=> emu_buffer_off == $past(avs_writedata[0]);
    endproperty
    a_emu_write: assert property (p_emu_write) else $error("emulation control bit not written");
    property p_eth_write;
        eth_take && avs_byteenable[2] |=> rmii_logic_reset == $past(avs_writedata[18]);
    endproperty
    a_eth_write: assert property (p_eth_write) else $error("rmii reset bit not written");
    property p_eth_hold;
        !eth_take |=> $stable(rmii_logic_reset);
    endproperty
    a_eth_hold: assert property (p_eth_hold) else $error("rmii reset bit changed without a write");
    property p_read_eth;
        done && $past(avs_read) && $past(avs_address) == ADDR_W'(`DCS_ETH_CFG_ADDR)
            |-> avs_readdata == {13'h0, rmii_logic_reset, 18'h0};
    endproperty
    a_read_eth: assert property (p_read_eth) else $error("ethernet config read back wrong");
    property p_read_status;
        done && $past(avs_read) && $past(avs_address) == ADDR_W'(`DCS_STATUS_ADDR)
            |-> avs_readdata[31:23] == 9'h0 && avs_readdata[16] && avs_readdata[8]
            && avs_readdata[22] == async_memif_pins_on && avs_readdata[10:9] == mac_interface_select;
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read back wrong");
    property p_valid_stays;
        status_valid |=> status_valid [*3];
    endproperty
    a_valid_stays: assert property (p_valid_stays) else $error("status valid dropped");
    property p_status_hold;
        status_valid && $past(status_valid) |-> $stable({async_memif_pins_on, mac_interface_select, boot_configuration});
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status field changed after capture");
    property p_capture;
        $rose(status_valid) |-> async_memif_pins_on == $past(async_memif_pin)
            && mac_interface_select == $past(mac_select_pins) && boot_configuration == $past(boot_mode_pins);
    endproperty
    a_capture: assert property (p_capture) else $error("status not latched from pins");
    property p_boot_onehot;
        status_valid && $past(status_valid) |-> boot_periph_enable == 16'h0001 << boot_configuration;
    endproperty
    a_boot_onehot: assert property (p_boot_onehot) else $error("boot peripheral enable wrong");

    c_capture: cover property ($rose(status_valid));
    c_eth_write: cover property (eth_take);
    c_slverr: cover property (done && avs_response == `DCS_RESP_SLVERR);
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "dcs_map.svh"

module tb_top;
    logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_address, avs_writedata, avs_readdata, strap, rd;
    logic [3:0] avs_byteenable;
    logic [1:0] avs_response, rsp;
    logic rmii_logic_reset, emu_buffer_off, async_memif_pins_on, dram_ctrl_pins_on, pci_pins_selected;
    logic clock_output_selected, byte_order_flag, status_valid;
    logic [16:0] emulation_pins_off;
    logic [2:0] boot_config_inputs;
    logic [1:0] mac_interface_select;
    logic [3:0] boot_configuration;
    logic [15:0] boot_periph_enable;
    logic [31:0] straps [4] = '{32'h0000_0040, 32'hFFFF_FFFF, 32'h0054_A2A5, 32'h002A_5D1A};
    int fail_count;
    int n_compared;

    dcs_regs #(.ADDR_W(32)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .async_memif_pin(strap[22]), .dram_ctrl_pin(strap[21]), .pci_select_pin(strap[20]),
        .boot_config_pins(strap[19:17]), .clock_output_pin(strap[15]), .serial_port1_pin(strap[14]),
        .pci_fast_pin(strap[13]), .serial_link_pin(strap[12]), .pci_eeprom_pin(strap[11]),
        .mac_select_pins(strap[10:9]), .cell_if_pin(strap[7]), .byte_order_pin(strap[6]),
        .host_wide_pin(strap[5]), .memif_clock_pin(strap[4]), .boot_mode_pins(strap[3:0]),
        .rmii_logic_reset(rmii_logic_reset), .emu_buffer_off(emu_buffer_off),
        .emulation_pins_off(emulation_pins_off), .async_memif_pins_on(async_memif_pins_on),
        .dram_ctrl_pins_on(dram_ctrl_pins_on), .pci_pins_selected(pci_pins_selected),
        .boot_config_inputs(boot_config_inputs), .clock_output_selected(clock_output_selected),
        .mac_interface_select(mac_interface_select), .byte_order_flag(byte_order_flag),
        .boot_configuration(boot_configuration), .boot_periph_enable(boot_periph_enable),
        .status_valid(status_valid)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Holds the request until waitrequest is sampled low, then idles one cycle before returning.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                fail_count++;
                test_done();
            end
            @(posedge sys_clk);
        end
        rd = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic do_reset(input logic [31:0] s);
        rst_b <= 1'b0;
        strap <= s;
        repeat (6) @(posedge sys_clk);
        chk("valid in reset", 32'h0, 32'(status_valid));
        chk("endian default", 32'h1, 32'(byte_order_flag));
        chk("rmii default", 32'h0, 32'(rmii_logic_reset));
        chk("emu default", 32'h0, 32'(emu_buffer_off));
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask

    initial begin
        rst_b = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 32'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        strap = 32'h0;
        for (int i = 0; i < 4; i++) begin
            do_reset(straps[i]);
            xfer(1'b0, `DCS_STATUS_ADDR, 32'h0, 4'hF);
            chk("status", (straps[i] & 32'h007E_FEFF) | 32'h0001_0100, rd);
            chk("status read resp", 32'(`DCS_RESP_OKAY), 32'(rsp));
            chk("valid after capture", 32'h1, 32'(status_valid));
            chk("boot mode", 32'(straps[i][3:0]), 32'(boot_configuration));
            chk("mac select", 32'(straps[i][10:9]), 32'(mac_interface_select));
            chk("endian", 32'(straps[i][6]), 32'(byte_order_flag));
            chk("async pins", 32'(straps[i][22]), 32'(async_memif_pins_on));
            chk("dram pins", 32'(straps[i][21]), 32'(dram_ctrl_pins_on));
            chk("pci select", 32'(straps[i][20]), 32'(pci_pins_selected));
            chk("config inputs", 32'(straps[i][19:17]), 32'(boot_config_inputs));
            chk("clock out", 32'(straps[i][15]), 32'(clock_output_selected));
            chk("boot enable", 32'h1 << straps[i][3:0], 32'(boot_periph_enable));
        end
        // The status register must ignore both a bus write and later pin activity.
        xfer(1'b1, `DCS_STATUS_ADDR, 32'h0000_0000, 4'hF);
        chk("status write resp", 32'(`DCS_RESP_OKAY), 32'(rsp));
        strap <= ~straps[3];
        repeat (4) @(posedge sys_clk);
        xfer(1'b0, `DCS_STATUS_ADDR, 32'h0, 4'hF);
        chk("status held", 32'h002B_5D1A, rd);
        // Software keeps reserved bits at their defaults and only sets the reset bit.
        xfer(1'b1, `DCS_ETH_CFG_ADDR, 32'h0004_0000, 4'hF);
        chk("rmii set", 32'h1, 32'(rmii_logic_reset));
        xfer(1'b0, `DCS_ETH_CFG_ADDR, 32'h0, 4'hF);
        chk("eth read", 32'h0004_0000, rd);
        xfer(1'b1, `DCS_ETH_CFG_ADDR, 32'h0, 4'hB);
        chk("rmii lane off", 32'h1, 32'(rmii_logic_reset));
        xfer(1'b1, `DCS_ETH_CFG_ADDR, 32'h0, 4'hF);
        chk("rmii clear", 32'h0, 32'(rmii_logic_reset));
        xfer(1'b1, `DCS_EMU_BUF_ADDR, 32'h0000_0001, 4'hF);
        chk("emu pins", 32'h0001_FFFF, 32'(emulation_pins_off));
        xfer(1'b0, `DCS_EMU_BUF_ADDR, 32'h0, 4'hF);
        chk("emu read", 32'h0000_0001, rd);
        xfer(1'b1, `DCS_EMU_BUF_ADDR, 32'hFFFF_FFFE, 4'hF);
        chk("emu off", 32'h0, 32'(emu_buffer_off));
        xfer(1'b0, 32'h02AC_0024, 32'h0, 4'hF);
        chk("unmapped resp", 32'(`DCS_RESP_SLVERR), 32'(rsp));
        chk("unmapped data", 32'h0, rd);
        xfer(1'b1, `DCS_EMU_BUF_ADDR, 32'h0000_0001, 4'hF);
        do_reset(straps[0]);
        test_done();
    end
endmodule

bind dcs_regs dcs_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response),
    .async_memif_pin(async_memif_pin),
    .mac_select_pins(mac_select_pins),
    .boot_mode_pins(boot_mode_pins),
    .rmii_logic_reset(rmii_logic_reset),
    .emu_buffer_off(emu_buffer_off),
    .emulation_pins_off(emulation_pins_off),
    .async_memif_pins_on(async_memif_pins_on),
    .mac_interface_select(mac_interface_select),
    .boot_configuration(boot_configuration),
    .boot_periph_enable(boot_periph_enable),
    .status_valid(status_valid)
);
